// ### chdm_host_mem.sv
// Purpose: host memory bus responder for the transfer block
// Assumes: grant is a level, done a one-cycle pulse
// Notes:   read data is a pattern of the address; writes are dropped
`timescale 1ns/1ps
module chdm_host_mem
	import chdm_pkg::*;
(
	// clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	// bus side
	input  wire chdm_hreq_t  i_hreq,
	input  wire logic        i_stall,
	output logic             o_grant,
	output logic             o_done,
	output logic      [15:0] o_rdata
);
	logic [1:0] wait_cnt;
	// grant unless stalled, finish the word one cycle after the grant
	always_ff @(posedge i_clk) begin
		if (i_rst || !i_hreq.req || i_stall) begin
			o_grant  <= 1'b0;
			o_done   <= 1'b0;
			wait_cnt <= 2'h0;
		end else begin
			o_grant  <= 1'b1;
			o_done   <= (wait_cnt == 2'h1);
			wait_cnt <= wait_cnt + 2'h1;
		end
	end
	// outside done the lines carry junk, never the real word
	assign o_rdata = o_done ? (i_hreq.addr[15:0] ^ 16'h5a5a)
		: ~i_hreq.addr[15:0];
endmodule

// ### chdm_pkg.sv
// Purpose: shared constants and carriers for the channel/host transfer block
// Assumes: 100 MHz clock, plain register port with one-cycle read latency
// Notes:   offsets are word indices on the register port
package chdm_pkg;
	localparam int unsigned CLK_MHZ = 100;
	// register offsets
	localparam logic [3:0] ADDR_DATA   = 4'h0;
	localparam logic [3:0] ADDR_WADDR  = 4'h1;
	localparam logic [3:0] ADDR_CTRL   = 4'h2;
	localparam logic [3:0] ADDR_STAT   = 4'h3;
	localparam logic [3:0] ADDR_MASK   = 4'h4;
	// control register fields
	localparam int CTL_PARITY_ERROR_STOP  = 0;
	localparam int CTL_RESPONSE_TIMEOUT_DISABLE  = 1;
	localparam int CTL_MAINT_CLOCK_ENABLE_ALT  = 2;
	localparam int CTL_XBA_LO  = 3;
	localparam int CTL_XBA_HI  = 4;
	localparam int CTL_ODD     = 5;
	localparam int CTL_TSFF    = 6;
	localparam int CTL_MCLKF   = 7;
	// status (sticky event) fields
	localparam int ST_ADDRESS_PARITY_GOOD   = 0;
	localparam int ST_RESP_TO = 1;
	localparam int ST_GNT_TO  = 2;
	localparam int ST_PARERR  = 3;
	localparam int ST_STOP    = 4;
	localparam int ST_W       = 5;
	localparam logic [15:0] RST_WORD = 16'h0000;
	// timing
	localparam int unsigned RESP_TO_MS   = 5000;
	localparam int unsigned RESP_TO_CYC  = RESP_TO_MS * 1000 * CLK_MHZ;
	localparam int unsigned GNT_TO_US    = 10;
	localparam int unsigned GNT_TO_CYC   = GNT_TO_US * CLK_MHZ;
	localparam int unsigned TMR_W        = 32;

	// host bus request carrier
	typedef struct packed {
		logic        req;
		logic        wr;
		logic [17:0] addr;
		logic [15:0] wdata;
	} chdm_hreq_t;

	// channel outbound byte with parity
	typedef struct packed {
		logic       par;
		logic [7:0] data;
	} chdm_cbyte_t;

	typedef enum logic [1:0] {
		CHDM_PURP_DATA,
		CHDM_PURP_STATUS,
		CHDM_PURP_LOG
	} chdm_purp_t;
endpackage

// ### chdm_timer.sv
// Purpose: restartable timeout counter
// Assumes: synchronous reset, one clock
// Notes:   non-sticky expiry pulse output, one cycle at terminal count
`timescale 1ns/1ps
module chdm_timer #(
	parameter logic [31:0] LIMIT = 32'h0000_0064
) (
	// clock and reset
	input  wire logic i_clk,
	input  wire logic i_rst,
	// control
	input  wire logic i_run,
	input  wire logic i_restart,
	// expiry
	output logic      o_expire
);
	logic [31:0] count;

	// counts while running; restart or idle clears
	always_ff @(posedge i_clk) begin
		if (i_rst || i_restart || !i_run) begin
			count <= 32'h0;
			o_expire <= 1'b0;
		end else begin
			count <= (count == LIMIT) ? count : count + 32'h1;
			o_expire <= (count == LIMIT - 32'h1);
		end
	end
endmodule

// ### chdm_top.sv
// Purpose: transfer datapath and error supervision of the channel bridge
// Assumes: inputs synchronous to i_clk; host bus grant is a level
// Notes:   long timeouts are parameters so simulation can shorten them
`timescale 1ns/1ps

// Behaviour
// [RULE1] Each word moved by memory transfer is held in the data register.
// [RULE2] The channel address byte is checked for odd parity, good sets a flag.
// [RULE3] With operational-in up and no software access in 5 s, flag an error.
// [RULE4] Flag an error when bus mastership is not granted in the interval.
// [RULE5] In maintenance clock mode the time state moves only on pulses.
// [RULE6] Each pulse toggles the maintenance flop; set and clear step a state.
// [RULE7] Address bit zero lives in an odd flop and reads back as zero.
// [RULE8] The odd flop initialises the byte alternator.
// [RULE9] During data transfer the address register is the word address.
// [RULE10] During channel selection it points at the status word.
// [RULE11] When logging it is the address of the event table entry.
// [RULE12] With parity stop set, a bad outbound byte ends the transfer.
// [RULE13] With parity stop clear, the error is flagged and transfer goes on.
// [RULE14] The byte alternator tracks the half of the current word.
// [RULE15] Address steps by two per word; overflow flips extended bits.
// [RULE16] Both timeouts count this clock, restart on events, clear on reset.
module chdm_top #(
	parameter logic [31:0] RESP_LIMIT = chdm_pkg::RESP_TO_CYC,
	parameter logic [31:0] GNT_LIMIT  = chdm_pkg::GNT_TO_CYC
) (
	// clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	// register port
	input  wire logic [3:0]  i_addr,
	input  wire logic [15:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [15:0] o_rdata,
	// channel side
	input  wire logic        i_opl_in,
	input  wire logic        i_addr_valid,
	input  wire chdm_pkg::chdm_cbyte_t i_bus_out,
	input  wire logic        i_byte_valid,
	// sequencer side
	input  wire logic        i_xfer_active,
	input  wire logic        i_xfer_dir_in,
	input  wire chdm_pkg::chdm_purp_t  i_purpose,
	input  wire logic        i_maint_pulse,
	input  wire logic        i_ts_advance,
	// host bus master
	output chdm_pkg::chdm_hreq_t       o_hreq,
	input  wire logic        i_grant,
	input  wire logic        i_done,
	input  wire logic [15:0] i_hrdata,
	// outputs to sequencer and software
	output logic      [7:0]  o_byte_in,
	output logic             o_xfer_stop,
	output logic             o_time_state,
	output logic             o_irq
);
	import chdm_pkg::*;

	logic [15:0]     data_word;
	logic [15:1]     waddr;
	logic            odd_flop;
	logic [1:0]      xba;
	logic            par_stop, tim_dis, mclk_en, mclk_flop, mclk_prev;
	logic            byte_alternator_flop, time_state;
	logic [ST_W-1:0] status, mask;
	logic            req_pend;
	logic            resp_exp, gnt_exp;

	// decode
	wire wr_data  = i_wr && (i_addr == ADDR_DATA);
	wire wr_waddr = i_wr && (i_addr == ADDR_WADDR);
	wire wr_ctrl  = i_wr && (i_addr == ADDR_CTRL);
	wire wr_stat  = i_wr && (i_addr == ADDR_STAT);
	wire wr_mask  = i_wr && (i_addr == ADDR_MASK);
	wire sw_touch = i_wr || i_rd;

	// [RULE2] odd parity check
	wire par_good  = ^{i_bus_out.par, i_bus_out.data};
	wire addr_ok   = i_addr_valid && par_good;
	// [RULE12] [RULE13] outbound data parity error
	wire data_perr = i_byte_valid && !par_good && i_xfer_active;
	wire stop_now  = data_perr && par_stop;

	// [RULE15] increment by two, overflow flips extended bits
	wire [15:0] waddr_inc = {1'b0, waddr} + 16'h1;
	wire        carry     = waddr_inc[15];
	wire        word_done = o_hreq.req && i_done;

	// [RULE5] [RULE6] one full flop cycle (set then clear) steps the state
	wire mclk_step = mclk_prev && !mclk_flop;
	wire ts_step   = mclk_en ? mclk_step : i_ts_advance;

	// [RULE14] byte unpack for channel: alternator picks the half
	wire [7:0] cur_byte = byte_alternator_flop ? data_word[15:8] : data_word[7:0];
	// [RULE14] in data transfers inbound words go out only once the upper half is packed,
	// so memory never sees a half-built data word
	wire        in_full   = i_byte_valid && i_xfer_dir_in && byte_alternator_flop;
	wire [15:0] in_word   = {i_bus_out.data, data_word[7:0]};
	wire want_word = i_xfer_active && !o_xfer_stop && !req_pend
		&& (i_purpose != CHDM_PURP_DATA || in_full || !i_xfer_dir_in);

	wire [ST_W-1:0] ev = {stop_now, data_perr, gnt_exp, resp_exp, addr_ok};

	// [RULE7] readback, word address bit zero always zero
	wire [15:0] ctrl_rd = {8'h00, mclk_flop, time_state, odd_flop,
		xba[1], xba[0], mclk_en, tim_dis, par_stop};
	wire [15:0] rd_mux =
		(i_addr == ADDR_DATA)  ? data_word :
		(i_addr == ADDR_WADDR) ? {waddr, 1'b0} :
		(i_addr == ADDR_CTRL)  ? ctrl_rd :
		(i_addr == ADDR_STAT)  ? {11'h0, status} :
		(i_addr == ADDR_MASK)  ? {11'h0, mask} : 16'h0000;

	// [RULE3] [RULE16] software response timer
	chdm_timer #(.LIMIT(RESP_LIMIT)) u_resp (
		.i_clk     (i_clk),
		.i_rst     (i_rst),
		.i_run     (i_opl_in && !tim_dis),
		.i_restart (sw_touch),
		.o_expire  (resp_exp)
	);

	// [RULE4] [RULE16] bus grant timer restarts per request
	chdm_timer #(.LIMIT(GNT_LIMIT)) u_gnt (
		.i_clk     (i_clk),
		.i_rst     (i_rst),
		.i_run     (o_hreq.req && !i_grant),
		.i_restart (word_done),
		.o_expire  (gnt_exp)
	);

	// control bits
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			{par_stop, tim_dis, mclk_en} <= 3'h0;
		end else if (wr_ctrl) begin
			par_stop <= i_wdata[CTL_PARITY_ERROR_STOP];
			tim_dis  <= i_wdata[CTL_RESPONSE_TIMEOUT_DISABLE];
			mclk_en  <= i_wdata[CTL_MAINT_CLOCK_ENABLE_ALT];
		end
	end

	// [RULE6] maintenance flop toggles per pulse
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			mclk_flop <= 1'b0;
			mclk_prev <= 1'b0;
		end else begin
			mclk_flop <= (mclk_en && i_maint_pulse) ? !mclk_flop : mclk_flop;
			mclk_prev <= mclk_flop;
		end
	end

	// [RULE5] time state holds unless stepped
	always_ff @(posedge i_clk) begin
		if (i_rst)
			time_state <= 1'b1;
		else if (ts_step)
			time_state <= !time_state;
	end

	// [RULE7] [RULE9] [RULE10] [RULE11] [RULE15] word address and odd flop
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			waddr    <= 15'h0;
			odd_flop <= 1'b0;
			xba      <= 2'h0;
		end else if (wr_waddr) begin
			waddr    <= i_wdata[15:1];
			odd_flop <= i_wdata[0];
		end else if (wr_ctrl) begin
			xba <= {i_wdata[CTL_XBA_HI], i_wdata[CTL_XBA_LO]};
		end else if (word_done && i_purpose == CHDM_PURP_DATA
			&& (byte_alternator_flop || o_hreq.wr)) begin
			waddr <= waddr_inc[14:0];
			if (carry)
				xba <= ~xba;
		end
	end

	// [RULE8] [RULE14] byte alternator
	always_ff @(posedge i_clk) begin
		if (i_rst)
			byte_alternator_flop <= 1'b0;
		else if (!i_xfer_active)
			byte_alternator_flop <= odd_flop;
		else if (i_byte_valid)
			byte_alternator_flop <= !byte_alternator_flop;
	end

	// [RULE1] data word capture and host request
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			data_word <= RST_WORD;
			o_hreq    <= '0;
			req_pend  <= 1'b0;
		end else begin
			if (wr_data)
				data_word <= i_wdata;
			else if (word_done && !o_hreq.wr)
				data_word <= i_hrdata;
			else if (i_byte_valid && i_xfer_dir_in)
				data_word <= byte_alternator_flop ? {i_bus_out.data, data_word[7:0]}
					: {data_word[15:8], i_bus_out.data};
			if (word_done || gnt_exp || stop_now) begin
				o_hreq.req <= 1'b0;
				req_pend   <= 1'b0;
			end else if (want_word) begin
				o_hreq.req   <= 1'b1;
				o_hreq.wr    <= i_xfer_dir_in;
				o_hreq.addr  <= {xba, waddr, 1'b0};
				o_hreq.wdata <= in_full ? in_word : data_word;
				req_pend     <= 1'b1;
			end
		end
	end

	// sticky status: set beats write-one-clear
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			status <= '0;
			mask   <= '0;
		end else begin
			status <= (status & ~(wr_stat ? i_wdata[ST_W-1:0] : '0)) | ev;
			if (wr_mask)
				mask <= i_wdata[ST_W-1:0];
		end
	end

	// registered outputs
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_rdata      <= 16'h0;
			o_byte_in    <= 8'h0;
			o_xfer_stop  <= 1'b0;
			o_time_state <= 1'b1;
			o_irq        <= 1'b0;
		end else begin
			o_rdata      <= i_rd ? rd_mux : 16'h0;
			o_byte_in    <= cur_byte;
			// [RULE12] stop held until transfer ends
			o_xfer_stop  <= i_xfer_active && (o_xfer_stop || stop_now);
			o_time_state <= time_state;
			o_irq        <= |(((status | ev) & mask));
		end
	end
endmodule

// ### chdm_top_monitor.sv
// Purpose: port assertions for chdm_top
// Assumes: one clock, synchronous reset
// Notes:   waits follow the hand-over timing
`timescale 1ns/1ps
module chdm_top_monitor
	import chdm_pkg::*;
(
	// watched ports
	input wire logic        i_clk, i_rst, i_wr, i_rd,
	input wire logic        i_byte_valid, i_grant, i_done,
	input wire logic [3:0]  i_addr,
	input wire chdm_cbyte_t i_bus_out,
	input wire logic [15:0] o_rdata,
	input wire chdm_hreq_t  o_hreq,
	input wire logic        o_xfer_stop, o_time_state, o_irq
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	// read data shows only in the slot after a read
	rd_idle_a: assert property (!$past(i_rd) |-> o_rdata == 16'h0)
		else $error("read data outside its slot");
	odd_read_a: assert property ($past(i_rd) && $past(i_addr) == ADDR_WADDR |-> !o_rdata[0])
		else $error("address bit zero read as one");
	hreq_even_a: assert property (o_hreq.req |-> !o_hreq.addr[0])
		else $error("odd address on host bus");
	reset_out_a: assert property ($fell(i_rst) |-> o_time_state && !o_irq && !o_xfer_stop && !o_hreq.req)
		else $error("outputs wrong after reset");
	stop_cause_a: assert property ($rose(o_xfer_stop) |-> $past(i_byte_valid) && !(^$past(i_bus_out)))
		else $error("stop without bad byte");
	req_hold_a: assert property (o_hreq.req && i_grant && !i_done && !i_byte_valid |=> $stable(o_hreq))
		else $error("host request moved before done");
	unmapped_a: assert property (i_rd && i_addr > ADDR_MASK |=> o_rdata == 16'h0)
		else $error("unmapped read not zero");
	irq_fall_a: assert property ($fell(o_irq) |-> $past(i_wr, 2))
		else $error("interrupt fell without a write");
	// main scenarios reached
	cover property (o_hreq.req && i_done);
	cover property ($rose(o_xfer_stop));
	cover property ($rose(o_irq));
	cover property ($fell(o_time_state));
endmodule
bind chdm_top chdm_top_monitor u_mon (.i_clk(i_clk), .i_rst(i_rst),
	.i_wr(i_wr), .i_rd(i_rd), .i_byte_valid(i_byte_valid),
	.i_grant(i_grant), .i_done(i_done), .i_addr(i_addr),
	.i_bus_out(i_bus_out), .o_rdata(o_rdata), .o_hreq(o_hreq),
	.o_xfer_stop(o_xfer_stop), .o_time_state(o_time_state), .o_irq(o_irq));

// ### chdm_top_test.sv
// Purpose: self-checking bench for chdm_top
// Assumes: shortened timeouts, partner answers on the host bus
// Notes:   maintenance pulses and time steps are driven only in t_maint
`timescale 1ns/1ps
module chdm_top_test;
	import chdm_pkg::*;
	logic        i_clk, i_rst, wr, rd, opl, av, bv, xa, stall;
	logic        dir, mp, tsa;
	logic        grant, done;
	logic [3:0]  addr;
	logic [15:0] wdata, rdata, hrdata, v;
	logic [7:0]  byte_in;
	logic        xstop, tstate, irq;
	chdm_cbyte_t bus_out;
	chdm_purp_t  purpose;
	chdm_hreq_t  hreq;
	int          bad_count, comparisons;
	chdm_top #(.RESP_LIMIT(32'd50), .GNT_LIMIT(32'd20)) DUT (.i_clk(i_clk),
		.i_rst(i_rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
		.i_rd(rd), .o_rdata(rdata), .i_opl_in(opl), .i_addr_valid(av),
		.i_bus_out(bus_out), .i_byte_valid(bv), .i_xfer_active(xa),
		.i_xfer_dir_in(dir), .i_purpose(purpose), .i_maint_pulse(mp),
		.i_ts_advance(tsa), .o_hreq(hreq), .i_grant(grant),
		.i_done(done), .i_hrdata(hrdata), .o_byte_in(byte_in),
		.o_xfer_stop(xstop), .o_time_state(tstate), .o_irq(irq));
	chdm_host_mem u_mem (.i_clk(i_clk), .i_rst(i_rst), .i_hreq(hreq),
		.i_stall(stall), .o_grant(grant), .o_done(done), .o_rdata(hrdata));
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// bus cycles start and end at a rising edge
	task automatic wreg(logic [3:0] a, logic [15:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge i_clk);
		wr <= 1'b0;
		// one idle edge so a following write never re-drives wr at once
		@(posedge i_clk);
	endtask
	task automatic rreg(logic [3:0] a);
		addr <= a;
		rd <= 1'b1;
		@(posedge i_clk);
		rd <= 1'b0;
		#1 v = rdata;
		@(posedge i_clk);
	endtask
	task automatic wait_req(logic lvl);
		int n;
		for (n = 0; n < 40 && hreq.req !== lvl; n++) @(posedge i_clk);
		if (hreq.req !== lvl) begin
			bad_count++;
			conclude();
		end
	endtask
	task automatic t_regs();
		wreg(ADDR_WADDR, 16'h1235);
		rreg(ADDR_WADDR);
		chk("word address", v, 16'h1234);
		wreg(ADDR_DATA, 16'hbeef);
		rreg(ADDR_DATA);
		chk("data word", v, 16'hbeef);
		rreg(4'hf);
		chk("unmapped", v, 16'h0);
		$display("registers done");
	endtask
	task automatic t_parity();
		wreg(ADDR_MASK, 16'h0);
		bus_out <= '{par: 1'b0, data: 8'h07};
		av <= 1'b1;
		@(posedge i_clk);
		av <= 1'b0;
		rreg(ADDR_STAT);
		chk("parity good", v[ST_ADDRESS_PARITY_GOOD], 1'b1);
		chk("masked irq", irq, 1'b0);
		wreg(ADDR_MASK, 16'h001f);
		@(posedge i_clk);
		chk("irq", irq, 1'b1);
		wreg(ADDR_STAT, 16'h001f);
		@(posedge i_clk);
		chk("irq cleared", irq, 1'b0);
		$display("parity done");
	endtask
	task automatic t_xfer();
		for (int p = 0; p < 3; p++) begin
			wreg(ADDR_CTRL, 16'h0018);
			wreg(ADDR_WADDR, 16'h0103);
			purpose <= chdm_purp_t'(p);
			xa <= 1'b1;
			wait_req(1'b1);
			chk("host addr", hreq.addr, 18'h30102);
			wait_req(1'b0);
			xa <= 1'b0;
			rreg(ADDR_DATA);
			chk("held word", v, 16'h0102 ^ 16'h5a5a);
		end
		$display("transfers done");
	endtask
	task automatic t_carry();
		wreg(ADDR_CTRL, 16'h0008);
		wreg(ADDR_WADDR, 16'hffff);
		purpose <= CHDM_PURP_DATA;
		xa <= 1'b1;
		wait_req(1'b1);
		chk("top word", hreq.addr, 18'h1fffe);
		wait_req(1'b0);
		wait_req(1'b1);
		chk("wrapped addr", hreq.addr, 18'h20000);
		xa <= 1'b0;
		wait_req(1'b0);
		$display("carry done");
	endtask
	task automatic t_inbound();
		wreg(ADDR_CTRL, 16'h0000);
		wreg(ADDR_WADDR, 16'h0200);
		purpose <= CHDM_PURP_DATA;
		dir <= 1'b1;
		xa <= 1'b1;
		bus_out <= '{par: 1'b1, data: 8'h11};
		bv <= 1'b1;
		@(posedge i_clk);
		bus_out <= '{par: 1'b1, data: 8'h22};
		@(posedge i_clk);
		bv <= 1'b0;
		wait_req(1'b1);
		chk("write dir", hreq.wr, 1'b1);
		chk("packed word", hreq.wdata, 16'h2211);
		chk("write addr", hreq.addr, 18'h00200);
		wait_req(1'b0);
		xa <= 1'b0;
		dir <= 1'b0;
		rreg(ADDR_DATA);
		chk("inbound word", v, 16'h2211);
		chk("byte out", byte_in, 8'h11);
		rreg(ADDR_WADDR);
		chk("stepped addr", v, 16'h0202);
		$display("inbound done");
	endtask
	task automatic t_maint();
		wreg(ADDR_CTRL, 16'h0004);
		tsa <= 1'b1;
		@(posedge i_clk);
		tsa <= 1'b0;
		repeat (2) @(posedge i_clk);
		chk("held state", tstate, 1'b1);
		mp <= 1'b1;
		@(posedge i_clk);
		mp <= 1'b0;
		repeat (3) @(posedge i_clk);
		chk("half step", tstate, 1'b1);
		rreg(ADDR_CTRL);
		chk("maint flop", v[CTL_MCLKF], 1'b1);
		mp <= 1'b1;
		@(posedge i_clk);
		mp <= 1'b0;
		repeat (3) @(posedge i_clk);
		chk("full step", tstate, 1'b0);
		wreg(ADDR_CTRL, 16'h0000);
		tsa <= 1'b1;
		@(posedge i_clk);
		tsa <= 1'b0;
		repeat (2) @(posedge i_clk);
		chk("normal step", tstate, 1'b1);
		$display("maintenance done");
	endtask
	task automatic t_stop(logic stop_on);
		wreg(ADDR_CTRL, {15'h0, stop_on});
		xa <= 1'b1;
		bus_out <= '{par: 1'b1, data: 8'h01};
		bv <= 1'b1;
		@(posedge i_clk);
		bv <= 1'b0;
		rreg(ADDR_STAT);
		chk("parity error", v[ST_PARERR], 1'b1);
		chk("stop", xstop, stop_on);
		xa <= 1'b0;
		wreg(ADDR_STAT, 16'h001f);
		$display("parity stop done");
	endtask
	task automatic t_timeouts();
		stall <= 1'b1;
		xa <= 1'b1;
		opl <= 1'b1;
		repeat (60) @(posedge i_clk);
		rreg(ADDR_STAT);
		chk("grant timeout", v[ST_GNT_TO], 1'b1);
		chk("response timeout", v[ST_RESP_TO], 1'b1);
		stall <= 1'b0;
		xa <= 1'b0;
		opl <= 1'b0;
		$display("timeouts done");
	endtask
	initial begin
		{i_rst, wr, rd, opl, av, bv, xa, stall} = 8'h80;
		{addr, wdata, bus_out} = '0;
		{dir, mp, tsa} = 3'h0;
		purpose = CHDM_PURP_DATA;
		bad_count = 0;
		comparisons = 0;
		repeat (20) @(posedge i_clk);
		i_rst <= 1'b0;
		@(posedge i_clk);
		t_regs();
		t_parity();
		t_xfer();
		t_carry();
		t_inbound();
		t_stop(1'b0);
		t_stop(1'b1);
		t_timeouts();
		t_maint();
		conclude();
	end
endmodule
